/* File: core/pgp_pkg.sv */
// Constants shared by the packet GPIO and PWM port block
package pgp_pkg;
   // ==========================================================
   // Command and answer codes
   localparam logic [7:0] PGP_CMD_STORE = 8'h04;
   localparam logic [7:0] PGP_CMD_SET = 8'h22;
   localparam logic [7:0] PGP_CMD_READ = 8'h23;
   localparam logic [7:0] PGP_RSP_OK = 8'h40;
   localparam logic [7:0] PGP_RSP_ERR = 8'hC0;
   localparam logic [7:0] PGP_LEN_READ_RSP = 8'h04;
   // ==========================================================
   // Channel map and field limits
   localparam int PGP_NUM_GPIO = 5;
   localparam int PGP_NUM_CHAN = 13;
   localparam logic [7:0] PGP_NUM_CHAN_B = 8'h0D;
   localparam logic [7:0] PGP_VAL_HIGH = 8'h64;
   localparam logic [7:0] PGP_CFG_MAX = 8'h0F;
   localparam int PGP_CFG_FUNC_BIT = 3;
   // ==========================================================
   // Drive mode codes
   localparam logic [2:0] PGP_DM_UP_PD = 3'h0;
   localparam logic [2:0] PGP_DM_STRONG = 3'h1;
   localparam logic [2:0] PGP_DM_HIZ = 3'h2;
   localparam logic [2:0] PGP_DM_PU_DN = 3'h3;
   localparam logic [2:0] PGP_DM_UP_HIZ = 3'h4;
   localparam logic [2:0] PGP_DM_STRONG2 = 3'h5;
   localparam logic [2:0] PGP_DM_RSVD = 3'h6;
   localparam logic [2:0] PGP_DM_HIZ_DN = 3'h7;
   // ==========================================================
   // Factory boot state: value and configuration per channel
   localparam logic [7:0] PGP_FACT_VAL [PGP_NUM_CHAN] = '{default: 8'h00};
   localparam logic [3:0] PGP_FACT_CFG [PGP_NUM_CHAN] = '{4'h2, 4'h3, 4'h2, 4'h2, 4'h2,
      4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9};
   // ==========================================================
   // Timing
   localparam int PGP_CLK_PERIOD_NS = 4;
   localparam int PGP_SAMPLE_HZ = 32;
   localparam int PGP_SAMPLE_PERIOD_NS = 1000000000 / PGP_SAMPLE_HZ;
   localparam int PGP_SAMPLE_CYC = PGP_SAMPLE_PERIOD_NS / PGP_CLK_PERIOD_NS;
   localparam int PGP_PWM_PERIOD_NS = 10000000;
   localparam int PGP_PWM_STEPS = 100;
   localparam int PGP_PWM_STEP_CYC = PGP_PWM_PERIOD_NS / PGP_PWM_STEPS / PGP_CLK_PERIOD_NS;
endpackage

/* File: core/pgp_samp_if.sv */
// Link between the port core and one pin sampler
`timescale 1ns/1ns
interface pgp_samp_if;
   logic tick;
   logic pin;
   logic clr;
   logic level;
   logic rise;
   logic fall;
   modport sampler (input tick, input pin, input clr, output level, output rise, output fall);
   modport owner (output tick, output pin, output clr, input level, input rise, input fall);
endinterface

/* File: core/pgp_pwm_chan.sv */
// One PWM output channel compared against the shared step index
`timescale 1ns/1ns
module pgp_pwm_chan
   import pgp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [6:0] step,
   input wire logic [7:0] value,
   output logic level
);
   // ==========================================================
   // Compare
   wire full_on = (value >= PGP_VAL_HIGH);
   wire duty_on = ({1'b0, step} < value);

   // High for value steps out of each hundred, value 100 holds high
   always_ff @(posedge clk) begin
      if (!rst_n) level <= 1'b0;
      else level <= full_on | duty_on;
   end

   chk_pwm_full_high: assert property (@(posedge clk) disable iff (!rst_n)
      (value == PGP_VAL_HIGH) |=> level) else $error("full duty not high");
   chk_pwm_zero_low: assert property (@(posedge clk) disable iff (!rst_n)
      (value == 8'h00) |=> !level) else $error("zero duty not low");
endmodule

/* File: core/pgp_pin_sampler.sv */
// Slow input sampler with bounce rejection and sticky edge flags
`timescale 1ns/1ns
module pgp_pin_sampler
   import pgp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   pgp_samp_if.sampler sif
);
   // ==========================================================
   // Sampling
   logic prev;
   wire agree = sif.tick && (sif.pin == prev);
   wire set_rise = agree && sif.pin && !sif.level;
   wire set_fall = agree && !sif.pin && sif.level;

   // Level moves only when two samples in a row agree, so bounce is filtered
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev <= 1'b0;
         sif.level <= 1'b0;
      end else if (sif.tick) begin
         prev <= sif.pin;
         if (agree) sif.level <= sif.pin;
      end
   end

   // Flags stick until the owner clears them; a new edge beats the clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sif.rise <= 1'b0;
         sif.fall <= 1'b0;
      end else begin
         sif.rise <= set_rise | (sif.rise & !sif.clr);
         sif.fall <= set_fall | (sif.fall & !sif.clr);
      end
   end

   chk_rise_latched: assert property (@(posedge clk) disable iff (!rst_n)
      set_rise |=> (sif.rise && sif.level)) else $error("rising edge lost");
   chk_edge_cleared: assert property (@(posedge clk) disable iff (!rst_n)
      (sif.clr && !set_fall) |=> !sif.fall) else $error("fall flag not cleared");
endmodule

/* File: core/packet_gpio_pwm_port.sv */
// Command driven GPIO and LED port with PWM, drive modes and sampled inputs
// Notes on behaviour
// - Index 0-4 pins, 5-12 LEDs, rest refused
// - Two bytes set value, three add config
// - Value 0 low, 1-99 PWM, 100 high
// - Three-bit drive mode selects pad drive
// - Mode 110 answered with error, not applied
// - Function bit 0 gives default function
// - Pins 1-3 default power sense, power, reset
// - Inputs sampled at 32 Hz, bounce free
// - Rising and falling edges latched per pin
// - Sampling free running, short pulses missed
// - Read takes index, answers four bytes
// - Byte one: level, falling, rising bits
// - Level reports the actual sampled pin
// - Byte two returns the stored value
// - Byte three returns config, upper zero
// - Value and config saved as boot state
`timescale 1ns/1ns
module pgp_gpio_port
   import pgp_pkg::*;
#(
   parameter int SAMPLE_CYC = PGP_SAMPLE_CYC,
   parameter int PWM_STEP_CYC = PGP_PWM_STEP_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_type,
   input wire logic [7:0] cmd_len,
   input wire logic [7:0] cmd_d0,
   input wire logic [7:0] cmd_d1,
   input wire logic [7:0] cmd_d2,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic rsp_err,
   output logic [7:0] rsp_type,
   output logic [7:0] rsp_len,
   output logic [31:0] rsp_data,
   input wire logic boot_load,
   input wire logic atx_power_ctl,
   input wire logic atx_reset_ctl,
   output logic host_power_sense,
   input wire logic [PGP_NUM_GPIO-1:0] pin_in,
   output logic [PGP_NUM_GPIO-1:0] pin_out,
   output logic [PGP_NUM_GPIO-1:0] pin_oe,
   output logic [PGP_NUM_GPIO-1:0] pin_pull_up,
   output logic [PGP_NUM_GPIO-1:0] pin_pull_dn,
   output logic [PGP_NUM_CHAN-PGP_NUM_GPIO-1:0] led_output_channel
);
   localparam int SW = $clog2(SAMPLE_CYC);
   localparam int PW = $clog2(PWM_STEP_CYC);

   // ==========================================================
   // Stored channel state, live and boot copies
   logic [7:0] val [PGP_NUM_CHAN];
   logic [3:0] cfg [PGP_NUM_CHAN];
   logic [7:0] boot_val [PGP_NUM_CHAN];
   logic [3:0] boot_cfg [PGP_NUM_CHAN];

   // ==========================================================
   // Command decode
   wire accept = cmd_valid && cmd_ready;
   wire is_set = (cmd_type == PGP_CMD_SET);
   wire is_read = (cmd_type == PGP_CMD_READ);
   wire is_store = (cmd_type == PGP_CMD_STORE);
   wire len_two = (cmd_len == 8'h02);
   wire len_three = (cmd_len == 8'h03);
   wire idx_ok = (cmd_d0 < PGP_NUM_CHAN_B);
   wire [3:0] idx = cmd_d0[3:0];
   wire val_ok = (cmd_d1 <= PGP_VAL_HIGH);
   // Upper bits of the config byte must be zero, and 110 is reserved
   wire cfg_ok = len_two || ((cmd_d2 <= PGP_CFG_MAX) && (cmd_d2[2:0] != PGP_DM_RSVD));
   wire set_ok = is_set && (len_two || len_three) && idx_ok && val_ok && cfg_ok;
   wire read_ok = is_read && (cmd_len == 8'h01) && idx_ok;
   wire store_ok = is_store && (cmd_len == 8'h00);
   wire cmd_ok = set_ok || read_ok || store_ok;
   wire do_set = accept && set_ok;
   wire do_cfg = do_set && len_three;
   wire do_read = accept && read_ok;
   wire do_store = accept && store_ok;

   // One command in flight; a restore of the boot state also holds commands off
   assign cmd_ready = !rsp_valid && !boot_load;

   // ==========================================================
   // Shared timebases
   logic [SW-1:0] samp_cnt;
   logic [PW-1:0] step_cnt;
   logic [6:0] step;
   wire samp_tick = (samp_cnt == SW'(SAMPLE_CYC - 1));
   wire step_wrap = (step_cnt == PW'(PWM_STEP_CYC - 1));
   wire step_last = (step == 7'(PGP_PWM_STEPS - 1));

   // Sample tick runs on its own, never aligned to host traffic
   always_ff @(posedge clk) begin
      if (!rst_n) samp_cnt <= '0;
      else if (samp_tick) samp_cnt <= '0;
      else samp_cnt <= samp_cnt + SW'(1);
   end

   // Hundred steps per PWM period, each a fixed number of clocks
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         step_cnt <= '0;
         step <= 7'h00;
      end else if (step_wrap) begin
         step_cnt <= '0;
         step <= step_last ? 7'h00 : step + 7'h01;
      end else begin
         step_cnt <= step_cnt + PW'(1);
      end
   end

   // ==========================================================
   // PWM channels and input samplers
   logic [PGP_NUM_CHAN-1:0] pwm;
   logic [PGP_NUM_CHAN-1:0] chan_level;
   logic [PGP_NUM_CHAN-1:0] chan_rise;
   logic [PGP_NUM_CHAN-1:0] chan_fall;
   pgp_samp_if sif [PGP_NUM_GPIO] ();

   genvar g;
   generate
      for (g = 0; g < PGP_NUM_CHAN; g++) begin : g_chan
         pgp_pwm_chan u_pwm (
            .clk(clk),
            .rst_n(rst_n),
            .step(step),
            .value(val[g]),
            .level(pwm[g])
         );
      end
      for (g = 0; g < PGP_NUM_GPIO; g++) begin : g_samp
         // Read clears flags of the queried pin only
         assign sif[g].tick = samp_tick;
         assign sif[g].pin = pin_in[g];
         assign sif[g].clr = do_read && (idx == 4'(g));
         assign chan_level[g] = sif[g].level;
         assign chan_rise[g] = sif[g].rise;
         assign chan_fall[g] = sif[g].fall;
         pgp_pin_sampler u_samp (
            .clk(clk),
            .rst_n(rst_n),
            .sif(sif[g])
         );
      end
      // LEDs have no input path; they report their own driven level
      for (g = PGP_NUM_GPIO; g < PGP_NUM_CHAN; g++) begin : g_led
         assign chan_level[g] = pwm[g];
         assign chan_rise[g] = 1'b0;
         assign chan_fall[g] = 1'b0;
      end
   endgenerate

   assign led_output_channel = pwm[PGP_NUM_CHAN-1:PGP_NUM_GPIO];
   assign host_power_sense = chan_level[1];

   // ==========================================================
   // Pad drive
   // Returns {oe, out, pull_up, pull_dn} for a mode and wanted level
   function automatic logic [3:0] pad_drive(input logic [2:0] mode, input logic lvl);
      logic [3:0] d;
      d = 4'h0;
      unique case (mode)
         PGP_DM_UP_PD: d = lvl ? 4'hC : 4'h1;
         PGP_DM_STRONG, PGP_DM_STRONG2: d = {1'b1, lvl, 2'b00};
         PGP_DM_HIZ: d = 4'h0;
         PGP_DM_PU_DN: d = lvl ? 4'h2 : 4'h8;
         PGP_DM_UP_HIZ: d = lvl ? 4'hC : 4'h0;
         PGP_DM_HIZ_DN: d = lvl ? 4'h0 : 4'h8;
         default: d = 4'h0;
      endcase
      return d;
   endfunction

   // Default function levels: pin 1 is an input, pins 2 and 3 follow the ATX logic
   wire [PGP_NUM_GPIO-1:0] dflt_lvl = {1'b0, atx_reset_ctl, atx_power_ctl, 1'b0, 1'b0};
   logic [3:0] drv [PGP_NUM_GPIO];
   generate
      for (g = 0; g < PGP_NUM_GPIO; g++) begin : g_pad
         // Mode still applies when the default function owns the pin
         wire want = cfg[g][PGP_CFG_FUNC_BIT] ? pwm[g] : dflt_lvl[g];
         assign drv[g] = pad_drive(cfg[g][2:0], want);
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               pin_oe[g] <= 1'b0;
               pin_out[g] <= 1'b0;
               pin_pull_up[g] <= 1'b0;
               pin_pull_dn[g] <= 1'b0;
            end else begin
               pin_oe[g] <= drv[g][3];
               pin_out[g] <= drv[g][2];
               pin_pull_up[g] <= drv[g][1];
               pin_pull_dn[g] <= drv[g][0];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Channel state and boot copy
   // Reset puts the factory state in both copies; boot_load replays the boot copy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         val <= PGP_FACT_VAL;
         cfg <= PGP_FACT_CFG;
      end else if (boot_load) begin
         val <= boot_val;
         cfg <= boot_cfg;
      end else if (do_set) begin
         val[idx] <= cmd_d1;
         if (do_cfg) cfg[idx] <= cmd_d2[3:0];
      end
   end

   // Store copies value and config of every channel
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         boot_val <= PGP_FACT_VAL;
         boot_cfg <= PGP_FACT_CFG;
      end else if (do_store) begin
         boot_val <= val;
         boot_cfg <= cfg;
      end
   end

   // ==========================================================
   // Answer
   // Read answer bytes: index, flags, stored value, config with top nibble zero
   wire [7:0] flag_byte = {5'h00, chan_rise[idx], chan_fall[idx], chan_level[idx]};
   wire [31:0] read_data = {4'h0, cfg[idx], val[idx], flag_byte, cmd_d0};
   wire [7:0] next_type = cmd_ok ? (cmd_type | PGP_RSP_OK) : (cmd_type | PGP_RSP_ERR);

   // Answer is captured at acceptance, so edges after it wait for the next read
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_err <= 1'b0;
         rsp_type <= 8'h00;
         rsp_len <= 8'h00;
         rsp_data <= 32'h0000_0000;
      end else if (accept) begin
         rsp_valid <= 1'b1;
         rsp_err <= !cmd_ok;
         rsp_type <= next_type;
         rsp_len <= read_ok ? PGP_LEN_READ_RSP : 8'h00;
         rsp_data <= read_ok ? read_data : 32'h0000_0000;
      end else if (rsp_ready) begin
         rsp_valid <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_index_refused: assert property ((accept && (is_set || is_read) && !idx_ok) |=> (rsp_valid && rsp_err))
      else $error("out of range index accepted");
   chk_value_only_set: assert property ((do_set && len_two) |=>
      (val[$past(idx)] == $past(cmd_d1)) && (cfg[$past(idx)] == $past(cfg[idx])))
      else $error("two byte set touched config");
   chk_value_invalid: assert property ((accept && is_set && (cmd_d1 > PGP_VAL_HIGH)) |=> rsp_err)
      else $error("bad value not refused");
   chk_hiz_mode_pad: assert property ((cfg[0][2:0] == PGP_DM_HIZ) |=>
      (!pin_oe[0] && !pin_pull_up[0] && !pin_pull_dn[0]))
      else $error("hi-z mode drives pad");
   chk_reserved_mode: assert property ((accept && is_set && len_three && (cmd_d2[2:0] == PGP_DM_RSVD)) |=>
      (rsp_err && (cfg[$past(idx)] == $past(cfg[idx]))))
      else $error("reserved mode applied");
   chk_default_func: assert property (((cfg[2] == 4'h1) && !boot_load) |=> (pin_oe[2] && (pin_out[2] == $past(atx_power_ctl))))
      else $error("default function not routed");
   chk_read_answer: assert property (do_read |=> (rsp_valid && (rsp_len == PGP_LEN_READ_RSP) &&
      (rsp_data[7:0] == $past(cmd_d0)) && (rsp_data[23:16] == $past(val[idx]))))
      else $error("read answer wrong");
   chk_reserved_zero: assert property ((rsp_valid && (rsp_len == PGP_LEN_READ_RSP)) |->
      ((rsp_data[31:28] == 4'h0) && (rsp_data[15:11] == 5'h00)))
      else $error("reserved answer bits set");
   chk_store_restore: assert property ((do_store ##1 boot_load) |=> (val[0] == $past(val[0], 2)))
      else $error("boot state not restored");

   cov_read_with_edge: cover property (do_read && (chan_rise[idx] || chan_fall[idx]));
   cov_reserved_mode: cover property (accept && is_set && len_three && (cmd_d2[2:0] == PGP_DM_RSVD));
   cov_pwm_mid: cover property (do_set && (cmd_d1 == 8'h32));
   cov_store_load: cover property (do_store ##[1:20] boot_load);
endmodule

/* File: verif/pgp_host_model.sv */
// Host model that sends command packets and takes the answers
`timescale 1ns/1ns
module pgp_host_model
   import pgp_pkg::*;
(
   input wire logic clk,
   output logic cmd_valid,
   input wire logic cmd_ready,
   output logic [7:0] cmd_type,
   output logic [7:0] cmd_len,
   output logic [7:0] cmd_d0,
   output logic [7:0] cmd_d1,
   output logic [7:0] cmd_d2,
   input wire logic rsp_valid,
   output logic rsp_ready,
   input wire logic rsp_err,
   input wire logic [7:0] rsp_type,
   input wire logic [7:0] rsp_len,
   input wire logic [31:0] rsp_data
);
   // ==========================================================
   // Captured answer and count of stalled transfers
   logic r_err;
   logic [7:0] r_type;
   logic [7:0] r_len;
   logic [31:0] r_data;
   int hangs = 0;
   initial begin
      cmd_valid = 1'b0;
      {cmd_type, cmd_len, cmd_d0, cmd_d1, cmd_d2} = 40'h0;
      rsp_ready = 1'b0;
   end
   // One command held until taken; answer taken with random stalls
   // Handshakes are judged at the falling edge, where the settled values before the next rising edge stand
   task automatic xfer(input logic [7:0] t, l, a, b, c);
      int n;
      logic rdy;
      logic rr;
      logic take;
      n = 0;
      @(negedge clk);
      cmd_valid <= 1'b1;
      {cmd_type, cmd_len, cmd_d0, cmd_d1, cmd_d2} <= {t, l, a, b, c};
      rdy = cmd_ready;
      while (rdy !== 1'b1 && n < 50) begin
         @(negedge clk);
         rdy = cmd_ready;
         n++;
      end
      if (rdy !== 1'b1) hangs++;
      @(posedge clk);
      @(negedge clk);
      cmd_valid <= 1'b0;
      // Released fields carry garbage so stale bytes are never trusted
      {cmd_type, cmd_len, cmd_d0, cmd_d1, cmd_d2} <= ~{t, l, a, b, c};
      n = 0;
      take = 1'b0;
      while (!take && n < 50) begin
         @(negedge clk);
         rr = 1'($urandom_range(0, 1));
         rsp_ready <= rr;
         take = rr && (rsp_valid === 1'b1);
         n++;
      end
      if (!take) hangs++;
      // Answer still stands until the coming rising edge takes it
      {r_err, r_type, r_len, r_data} = {rsp_err, rsp_type, rsp_len, rsp_data};
      @(posedge clk);
      @(negedge clk);
      rsp_ready <= 1'b0;
   endtask
endmodule

/* File: verif/packet_gpio_pwm_port_tb_top.sv */
// Self-checking bench for the packet GPIO and PWM port
`timescale 1ns/1ns
module packet_gpio_pwm_port_tb_top;
   import pgp_pkg::*;
   // ==========================================================
   // Short counts keep the run brief
   localparam int SCYC = 8;
   localparam int PCYC = 2;
   logic clk = 1'b0, rst_n = 1'b0, cmd_valid, cmd_ready, rsp_valid, rsp_ready, rsp_err;
   logic [7:0] cmd_type, cmd_len, cmd_d0, cmd_d1, cmd_d2, rsp_type, rsp_len, st, sv;
   logic [31:0] rsp_data, cnt;
   logic boot_load = 1'b0, atx_power_ctl = 1'b0, atx_reset_ctl = 1'b0, host_power_sense, flt = 1'b0;
   logic [4:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_dn, ext = 5'h00, ext_en = 5'h00;
   logic [7:0] led_output_channel;
   logic [7:0] mv [PGP_NUM_CHAN];
   logic [3:0] mc [PGP_NUM_CHAN];
   logic [3:0] sc;
   logic [7:0] bad [4][2] = '{'{8'h22, 8'h01}, '{8'h23, 8'h02}, '{8'h1E, 8'h00}, '{8'h55, 8'h01}};
   logic [7:0] pv [5] = '{8'h00, 8'h01, 8'h1E, 8'h63, 8'h64};
   int miscompares = 0;
   int n_checks = 0;
   initial forever #2 clk = ~clk;
   always @(posedge clk) flt <= ~flt;
   // Pad levels: own drive wins, then outside source, then pulls, else a toggling float
   always_comb begin
      for (int i = 0; i < PGP_NUM_GPIO; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext[i];
         else if (pin_pull_up[i] | pin_pull_dn[i]) pin_in[i] = pin_pull_up[i];
         else pin_in[i] = flt;
      end
   end
   pgp_gpio_port #(.SAMPLE_CYC(SCYC), .PWM_STEP_CYC(PCYC)) DUT (.clk(clk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_type(cmd_type), .cmd_len(cmd_len),
      .cmd_d0(cmd_d0), .cmd_d1(cmd_d1), .cmd_d2(cmd_d2), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp_err(rsp_err), .rsp_type(rsp_type), .rsp_len(rsp_len), .rsp_data(rsp_data),
      .boot_load(boot_load), .atx_power_ctl(atx_power_ctl), .atx_reset_ctl(atx_reset_ctl),
      .host_power_sense(host_power_sense), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .led_output_channel(led_output_channel));
   pgp_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_type(cmd_type),
      .cmd_len(cmd_len), .cmd_d0(cmd_d0), .cmd_d1(cmd_d1), .cmd_d2(cmd_d2), .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready), .rsp_err(rsp_err), .rsp_type(rsp_type), .rsp_len(rsp_len),
      .rsp_data(rsp_data));
   // ==========================================================
   // Comparison, expectation and command helpers
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
      end
   endtask
   // Pad controls {oe, out, pull_up, pull_dn} for a drive mode and level
   function automatic logic [3:0] exp_pad(input logic [2:0] m, input logic lv);
      case (m)
         3'h0: return lv ? 4'hC : 4'h1;
         3'h1, 3'h5: return {1'b1, lv, 2'h0};
         3'h3: return lv ? 4'h2 : 4'h8;
         3'h4: return lv ? 4'hC : 4'h0;
         3'h7: return lv ? 4'h0 : 4'h8;
         default: return 4'h0;
      endcase
   endfunction
   task automatic do_set(input logic [7:0] i, v, c, l);
      logic ok;
      ok = i < PGP_NUM_CHAN_B && v <= PGP_VAL_HIGH;
      ok = ok && (l == 8'h02 || (l == 8'h03 && c <= PGP_CFG_MAX && c[2:0] != PGP_DM_RSVD));
      host.xfer(PGP_CMD_SET, l, i, v, c);
      chk("set type", {24'h0, ok ? 8'h62 : 8'hE2}, {24'h0, host.r_type});
      chk("set err", {31'h0, ~ok}, {31'h0, host.r_err});
      if (ok) mv[i] = v;
      if (ok && l == 8'h03) mc[i] = c[3:0];
   endtask
   task automatic do_read(input logic [7:0] i);
      host.xfer(PGP_CMD_READ, 8'h01, i, 8'h00, 8'h00);
      chk("read head", {8'h00, 8'h63, 8'h04, i}, {8'h00, host.r_type, host.r_len, host.r_data[7:0]});
      chk("read value", {24'h0, mv[i]}, {24'h0, host.r_data[23:16]});
      chk("read cfg", {28'h0, mc[i]}, {24'h0, host.r_data[31:24]});
      st = host.r_data[15:8];
   endtask
   task automatic print_verdict();
      chk("host hangs", 32'h0, host.hangs);
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      print_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'hD74E));
      mv = PGP_FACT_VAL;
      mc = PGP_FACT_CFG;
      repeat (2) @(negedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 13; k++) begin
         do_read(8'(k));
         chk("state top", 32'h0, {27'h0, st[7:3]});
      end
      // Sampled levels, sticky edges, glitch rejection
      do_set(8'h01, 8'h00, 8'h02, 8'h03);
      ext_en = 5'h03;
      ext[1] = 1'($urandom_range(0, 1));
      repeat (4 * SCYC) @(negedge clk);
      do_read(8'h00);
      do_read(8'h00);
      chk("quiet state", 32'h0, {24'h0, st});
      ext[0] = 1'b1;
      repeat (4 * SCYC) @(negedge clk);
      do_read(8'h00);
      chk("rise state", 32'h5, {24'h0, st});
      do_read(8'h00);
      chk("cleared state", 32'h1, {24'h0, st});
      ext[0] = 1'b0;
      repeat (3) @(negedge clk);
      ext[0] = 1'b1;
      repeat (4 * SCYC) @(negedge clk);
      do_read(8'h00);
      chk("glitch state", 32'h1, {24'h0, st});
      ext[0] = 1'b0;
      do_set(8'h00, 8'h64, 8'h0B, 8'h03);
      repeat (4 * SCYC) @(negedge clk);
      do_read(8'h00);
      chk("fall state", 32'h2, {24'h0, st});
      chk("power sense", {31'h0, ext[1]}, {31'h0, host_power_sense});
      ext_en = 5'h00;
      // Refused commands, then random settings read back
      for (int k = 0; k < 4; k++) begin
         host.xfer(bad[k][0], bad[k][1], 8'h00, 8'h00, 8'h00);
         chk("refused", {23'h0, 1'b1, bad[k][0] | 8'hC0}, {23'h0, host.r_err, host.r_type});
      end
      do_set(8'h0D, 8'h00, 8'h00, 8'h02);
      do_set(8'hFF, 8'h00, 8'h00, 8'h02);
      do_set(8'h04, 8'h65, 8'h00, 8'h02);
      do_set(8'h04, 8'h00, 8'h10, 8'h03);
      do_set(8'h04, 8'h00, 8'h0E, 8'h03);
      repeat (24) begin
         sv = 8'($urandom_range(0, 15));
         if (sv[2:0] == 3'h6) sv[2:0] = 3'h1;
         do_set(8'($urandom_range(0, 12)), 8'($urandom_range(0, 100)), sv, 8'($urandom_range(2, 3)));
      end
      for (int k = 0; k < 13; k++) do_read(8'(k));
      // Every drive mode except reserved 110 at both constant levels
      for (int m = 0; m < 8; m++) begin
         for (int lv = 0; lv < 2 && m != 6; lv++) begin
            do_set(8'h00, lv ? 8'h64 : 8'h00, 8'h08 | 8'(m), 8'h03);
            repeat (4) @(negedge clk);
            chk("pad ctl", {28'h0, exp_pad(3'(m), lv[0])}, {28'h0, pin_oe[0], pin_out[0], pin_pull_up[0], pin_pull_dn[0]});
         end
      end
      // Default function on pin 2 follows its control input
      do_set(8'h02, 8'h00, 8'h01, 8'h03);
      repeat (4) begin
         atx_power_ctl = 1'($urandom_range(0, 1));
         repeat (4) @(negedge clk);
         chk("atx pin", {30'h0, 1'b1, atx_power_ctl}, {30'h0, pin_oe[2], pin_out[2]});
      end
      // Duty measured over two whole PWM periods
      foreach (pv[k]) begin
         do_set(8'h05, pv[k], 8'h09, 8'h03);
         repeat (10) @(negedge clk);
         cnt = 32'h0;
         repeat (2 * 100 * PCYC) begin
            @(negedge clk);
            cnt = cnt + {31'h0, led_output_channel[0]};
         end
         chk("pwm high", 32'(pv[k]) * 2 * PCYC, cnt);
      end
      // Store boot state, disturb it, restore it
      host.xfer(PGP_CMD_STORE, 8'h00, 8'h00, 8'h00, 8'h00);
      chk("store", 32'h44, {15'h0, host.r_err, host.r_len, host.r_type});
      sv = mv[4];
      sc = mc[4];
      do_set(8'h04, 8'h4D, 8'h0F, 8'h03);
      boot_load = 1'b1;
      @(negedge clk);
      boot_load = 1'b0;
      mv[4] = sv;
      mc[4] = sc;
      do_read(8'h04);
      print_verdict();
   end
endmodule
